// [hw/clock_switch_pkg.sv]
// Purpose: shared constants and types for the cpu clock source switcher
// Assumes: one register per aligned 32-bit word, 8-bit data in bits 7:0
// Notes: stabilisation counts are in cycles of the x1 clock
package clock_switch_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W = 8;

  localparam logic [ADDR_W-1:0] OFS_OSC_RUN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SYS_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SUB_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STAB_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STAB_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SUPPLY = 8'h18;

  // oscillator_run_control
  localparam int unsigned HIGH_STOP_BIT = 0;
  localparam int unsigned MID_EN_BIT = 1;
  localparam int unsigned CSC_ONE_BIT = 6;
  localparam int unsigned X1_STOP_BIT = 7;
  // system_clock_select_status
  localparam int unsigned ONCHIP_SEL_BIT = 0;
  localparam int unsigned ONCHIP_STAT_BIT = 1;
  localparam int unsigned MAIN_SEL_BIT = 4;
  localparam int unsigned MAIN_STAT_BIT = 5;
  localparam int unsigned SUB_SEL_BIT = 6;
  localparam int unsigned CPU_STAT_BIT = 7;
  // subsystem_clock_select, subsystem_supply_mode_reg
  localparam int unsigned LOW_SEL_BIT = 0;
  localparam int unsigned WUT_BIT = 0;
  // clock_operation_mode
  localparam int unsigned GAIN_BIT = 0;
  localparam int unsigned X1_MODE_BIT = 6;
  localparam int unsigned EXT_BIT = 7;
  // stabilization_time_select
  localparam int unsigned STAB_SEL_W = 3;

  // reset: cpu runs from the low-speed oscillator, main sources stopped
  localparam logic RST_HIGH_STOP = 1'b1;
  localparam logic RST_MID_EN = 1'b0;
  localparam logic RST_X1_STOP = 1'b1;
  localparam logic RST_SUB_SEL = 1'b1;
  localparam logic RST_LOW_SEL = 1'b1;
  localparam logic [STAB_SEL_W-1:0] RST_STAB_SEL = 3'h7;

  localparam int unsigned CNT_W = 19;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    SRC_HIGH = 2'b00,
    SRC_MIDDLE = 2'b01,
    SRC_X1 = 2'b10,
    SRC_LOW = 2'b11
  } cpu_peripheral_clock_src_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_phase_type;

  // x1 edge count of each status flag, bit 7 first
  function automatic logic [CNT_W-1:0] stab_threshold(input logic [2:0] i);
    logic [4:0] e;
    e = 5'h08;
    case (i)
      3'h0: e = 5'h08;
      3'h1: e = 5'h09;
      3'h2: e = 5'h0A;
      3'h3: e = 5'h0B;
      3'h4: e = 5'h0D;
      3'h5: e = 5'h0F;
      3'h6: e = 5'h11;
      default: e = 5'h12;
    endcase
    return CNT_W'(1) << e;
  endfunction

endpackage

// [hw/x1_stab_counter.sv]
// Purpose: counts x1 edges after start and reports stabilisation flags
// Assumes: x1 clock below a third of the core clock
// Notes: external clock mode is reported stable as soon as it is run
`timescale 1ns/1ns
module x1_stab_counter
  import clock_switch_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic x1_pin_in,
  input wire logic run_in,
  input wire logic ext_in,
  input wire logic [STAB_SEL_W-1:0] sel_in,
  output logic [REG_W-1:0] status_out,
  output logic stable_out
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [CNT_W-1:0] cnt;
    logic [REG_W-1:0] status;
    logic stable;
  } stab_state_type;

  stab_state_type r_q;
  stab_state_type r_d;
  logic [CNT_W-1:0] limit;

  assign limit = stab_threshold(sel_in);

  always_comb begin
    r_d = r_q;
    r_d.sync1 = x1_pin_in;
    r_d.sync2 = r_q.sync1;
    r_d.prev = r_q.sync2;
    if (!run_in) begin
      r_d.cnt = '0;
    end else if (r_q.sync2 && !r_q.prev && r_q.cnt < limit) begin
      r_d.cnt = r_q.cnt + CNT_W'(1);
    end
    // flags fill from bit 7 downward as time passes
    for (int i = 0; i < REG_W; i++) begin
      r_d.status[REG_W-1-i] = r_q.cnt >= stab_threshold(3'(i));
    end
    r_d.stable = run_in && (ext_in || r_q.cnt >= limit);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_q <= '0;
    end else if (clk_en_in) begin
      r_q <= r_d;
    end
  end

  assign status_out = r_q.status;
  assign stable_out = r_q.stable;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_stab_flags_fill: assert property (
    (run_in && clk_en_in && $past(run_in))
      |=> ((r_q.status & $past(r_q.status)) == $past(r_q.status))
  ) else $error("stabilisation flag dropped while running");

  a_stab_limit_hold: assert property (
    (r_q.stable && !$past(ext_in)) |-> $past(r_q.cnt) >= $past(limit)
  ) else $error("x1 reported stable before selected count");

endmodule

// [hw/cpu_clock_source_switcher.sv]
// Purpose: cpu clock source control with an AHB-Lite register slave
// Assumes: one wait state on every transfer, word accesses only
// Notes: oscillator enables and the source select are registered outputs
`timescale 1ns/1ns
module cpu_clock_source_switcher
  import clock_switch_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CLK_EN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic X1_CLK_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic HIGH_OSC_RUN_OUT,
  output logic MIDDLE_OSC_RUN_OUT,
  output logic LOW_OSC_RUN_OUT,
  output logic X1_OSC_RUN_OUT,
  output logic X1_EXT_MODE_OUT,
  output logic X1_GAIN_HIGH_OUT,
  output logic [1:0] CPU_PERIPHERAL_CLOCK_SRC_OUT
);

  typedef struct packed {
    bus_phase_type phase;
    logic hready;
    logic [31:0] hrdata;
    logic pend_write;
    logic [ADDR_W-1:0] pend_addr;
    logic high_osc_stop;
    logic middle_osc_enable;
    logic x1_osc_stop;
    logic subsystem_clock_select;
    logic cpu_clock_source_status;
    logic main_system_clock_select;
    logic main_clock_source_status;
    logic onchip_osc_select;
    logic onchip_osc_status;
    logic low_osc_select;
    logic wakeup_timer_clock_supply;
    logic x1_mode_select;
    logic external_input_select;
    logic x1_gain_select;
    logic [STAB_SEL_W-1:0] stab_sel;
    logic high_run;
    logic middle_run;
    logic low_run;
    logic x1_run;
    logic ext_mode;
    logic gain_high;
    cpu_peripheral_clock_src_type cpu_peripheral_clock_src;
  } sw_state_type;

  sw_state_type r_q;
  sw_state_type r_d;
  logic [REG_W-1:0] stab_status;
  logic x1_stable;
  logic x1_started;
  logic onchip_ok;
  logic main_src_ok;
  logic low_ok;
  logic accept;
  logic wr_now;
  logic [REG_W-1:0] wdata;

  // the counter runs whenever x1 mode is on and x1 is not stopped, external input included; external input needs no wait
  assign x1_started = !r_q.x1_osc_stop && r_q.x1_mode_select;

  x1_stab_counter u_stab (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .clk_en_in(CLK_EN_IN),
    .x1_pin_in(X1_CLK_IN),
    .run_in(x1_started),
    .ext_in(r_q.external_input_select),
    .sel_in(r_q.stab_sel),
    .status_out(stab_status),
    .stable_out(x1_stable)
  );

  assign onchip_ok = r_q.onchip_osc_select ? r_q.middle_osc_enable
                                           : !r_q.high_osc_stop;
  assign main_src_ok = r_q.main_system_clock_select ? x1_stable : onchip_ok;
  assign low_ok = r_q.low_osc_select || r_q.wakeup_timer_clock_supply;
  assign accept = HSEL_IN && HREADY_IN && HTRANS_IN[1] && r_q.hready;
  assign wr_now = (r_q.phase == BUS_DATA) && !r_q.hready && r_q.pend_write;
  assign wdata = HWDATA_IN[REG_W-1:0];

  function automatic logic [REG_W-1:0] read_reg(input sw_state_type s,
      input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] stab);
    logic [REG_W-1:0] v;
    v = '0;
    case (a)
      OFS_OSC_RUN: begin
        v[HIGH_STOP_BIT] = s.high_osc_stop;
        v[MID_EN_BIT] = s.middle_osc_enable;
        v[CSC_ONE_BIT] = 1'b1;
        v[X1_STOP_BIT] = s.x1_osc_stop;
      end
      OFS_SYS_SEL: begin
        v[ONCHIP_SEL_BIT] = s.onchip_osc_select;
        v[ONCHIP_STAT_BIT] = s.onchip_osc_status;
        v[MAIN_SEL_BIT] = s.main_system_clock_select;
        v[MAIN_STAT_BIT] = s.main_clock_source_status;
        v[SUB_SEL_BIT] = s.subsystem_clock_select;
        v[CPU_STAT_BIT] = s.cpu_clock_source_status;
      end
      OFS_SUB_SEL: begin
        v[LOW_SEL_BIT] = s.low_osc_select;
      end
      OFS_MODE: begin
        v[GAIN_BIT] = s.x1_gain_select;
        v[X1_MODE_BIT] = s.x1_mode_select;
        v[EXT_BIT] = s.external_input_select;
      end
      OFS_STAB_SEL: begin
        v[STAB_SEL_W-1:0] = s.stab_sel;
      end
      OFS_STAB_STAT: begin
        v = stab;
      end
      OFS_SUPPLY: begin
        v[WUT_BIT] = s.wakeup_timer_clock_supply;
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  always_comb begin
    r_d = r_q;
    if (r_q.phase == BUS_DATA && !r_q.hready) begin
      r_d.hready = 1'b1;
      r_d.phase = BUS_IDLE;
      r_d.hrdata = '0;
      if (r_q.pend_write) begin
        case (r_q.pend_addr)
          OFS_OSC_RUN: begin
            r_d.high_osc_stop = wdata[HIGH_STOP_BIT];
            r_d.middle_osc_enable = wdata[MID_EN_BIT];
            r_d.x1_osc_stop = wdata[X1_STOP_BIT];
          end
          OFS_SYS_SEL: begin
            r_d.onchip_osc_select = wdata[ONCHIP_SEL_BIT];
            r_d.main_system_clock_select = wdata[MAIN_SEL_BIT];
            r_d.subsystem_clock_select = wdata[SUB_SEL_BIT];
          end
          OFS_SUB_SEL: begin
            r_d.low_osc_select = wdata[LOW_SEL_BIT];
          end
          OFS_MODE: begin
            r_d.x1_gain_select = wdata[GAIN_BIT];
            r_d.x1_mode_select = wdata[X1_MODE_BIT];
            r_d.external_input_select = wdata[EXT_BIT];
          end
          OFS_STAB_SEL: begin
            r_d.stab_sel = wdata[STAB_SEL_W-1:0];
          end
          OFS_SUPPLY: begin
            r_d.wakeup_timer_clock_supply = wdata[WUT_BIT];
          end
          default: begin
            r_d.hrdata = '0;
          end
        endcase
      end else begin
        r_d.hrdata = {{(32-REG_W){1'b0}},
                      read_reg(r_q, r_q.pend_addr, stab_status)};
      end
    end else if (accept) begin
      r_d.phase = BUS_DATA;
      r_d.hready = 1'b0;
      r_d.pend_write = HWRITE_IN;
      r_d.pend_addr = HADDR_IN[ADDR_W-1:0];
    end

    // status bits move only once the requested source is really running
    if (r_q.subsystem_clock_select && low_ok) begin
      r_d.cpu_clock_source_status = 1'b1;
    end else if (!r_q.subsystem_clock_select && main_src_ok) begin
      r_d.cpu_clock_source_status = 1'b0;
    end
    if (r_q.main_system_clock_select && x1_stable) begin
      r_d.main_clock_source_status = 1'b1;
    end else if (!r_q.main_system_clock_select && onchip_ok) begin
      r_d.main_clock_source_status = 1'b0;
    end
    if (onchip_ok) begin
      r_d.onchip_osc_status = r_q.onchip_osc_select;
    end

    r_d.high_run = !r_q.high_osc_stop;
    r_d.middle_run = r_q.middle_osc_enable;
    r_d.low_run = low_ok;
    r_d.x1_run = !r_q.x1_osc_stop && r_q.x1_mode_select;
    r_d.ext_mode = r_q.x1_mode_select && r_q.external_input_select;
    r_d.gain_high = r_q.x1_gain_select;
    if (r_q.cpu_clock_source_status) begin
      r_d.cpu_peripheral_clock_src = SRC_LOW;
    end else if (r_q.main_clock_source_status) begin
      r_d.cpu_peripheral_clock_src = SRC_X1;
    end else if (r_q.onchip_osc_status) begin
      r_d.cpu_peripheral_clock_src = SRC_MIDDLE;
    end else begin
      r_d.cpu_peripheral_clock_src = SRC_HIGH;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      r_q <= '0;
      r_q.hready <= 1'b1;
      r_q.high_osc_stop <= RST_HIGH_STOP;
      r_q.middle_osc_enable <= RST_MID_EN;
      r_q.x1_osc_stop <= RST_X1_STOP;
      r_q.subsystem_clock_select <= RST_SUB_SEL;
      r_q.cpu_clock_source_status <= RST_SUB_SEL;
      r_q.low_osc_select <= RST_LOW_SEL;
      r_q.stab_sel <= RST_STAB_SEL;
      r_q.low_run <= RST_LOW_SEL;
      r_q.cpu_peripheral_clock_src <= SRC_LOW;
    end else if (CLK_EN_IN) begin
      r_q <= r_d;
    end
  end

  assign HRDATA_OUT = r_q.hrdata;
  assign HREADYOUT_OUT = r_q.hready;
  assign HRESP_OUT = 1'b0;
  assign HIGH_OSC_RUN_OUT = r_q.high_run;
  assign MIDDLE_OSC_RUN_OUT = r_q.middle_run;
  assign LOW_OSC_RUN_OUT = r_q.low_run;
  assign X1_OSC_RUN_OUT = r_q.x1_run;
  assign X1_EXT_MODE_OUT = r_q.ext_mode;
  assign X1_GAIN_HIGH_OUT = r_q.gain_high;
  assign CPU_PERIPHERAL_CLOCK_SRC_OUT = r_q.cpu_peripheral_clock_src;

  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_high_osc_start: assert property (
    (wr_now && CLK_EN_IN && r_q.pend_addr == OFS_OSC_RUN
      && !wdata[HIGH_STOP_BIT]) ##1 CLK_EN_IN |=> HIGH_OSC_RUN_OUT
  ) else $error("high oscillator not started by write");

  a_mid_osc_start: assert property (
    (wr_now && CLK_EN_IN && r_q.pend_addr == OFS_OSC_RUN
      && wdata[MID_EN_BIT]) ##1 CLK_EN_IN |=> MIDDLE_OSC_RUN_OUT
  ) else $error("middle oscillator not started by write");

  a_cpu_to_main: assert property (
    (r_q.cpu_clock_source_status && !r_q.subsystem_clock_select
      && main_src_ok && CLK_EN_IN) |=> !r_q.cpu_clock_source_status
  ) else $error("cpu status did not leave subsystem clock");

  a_cpu_src_out: assert property (
    (r_q.cpu_clock_source_status && CLK_EN_IN) |=> CPU_PERIPHERAL_CLOCK_SRC_OUT == SRC_LOW
  ) else $error("source output disagrees with cpu status");

  a_low_osc_stop: assert property (
    (!r_q.low_osc_select && !r_q.wakeup_timer_clock_supply && CLK_EN_IN)
      |=> !LOW_OSC_RUN_OUT
  ) else $error("low oscillator still running");

  a_low_osc_keep: assert property (
    (r_q.wakeup_timer_clock_supply && CLK_EN_IN)[*2] |=> LOW_OSC_RUN_OUT
  ) else $error("low oscillator stopped while wakeup supply set");

  a_ext_mode_sel: assert property (
    CLK_EN_IN |=> X1_EXT_MODE_OUT
      == ($past(r_q.external_input_select) && $past(r_q.x1_mode_select))
  ) else $error("external mode output wrong");

  a_x1_start: assert property (
    (!r_q.x1_osc_stop && r_q.x1_mode_select && CLK_EN_IN) |=> X1_OSC_RUN_OUT
  ) else $error("x1 oscillator not started");

  a_main_status_x1: assert property (
    $rose(r_q.main_clock_source_status)
      |-> $past(x1_stable) && $past(r_q.main_system_clock_select)
  ) else $error("main status set without stable x1");

  a_onchip_status: assert property (
    (r_q.onchip_osc_status != r_q.onchip_osc_select && onchip_ok
      && CLK_EN_IN) |=> r_q.onchip_osc_status == $past(r_q.onchip_osc_select)
  ) else $error("on-chip status did not follow select");

  a_bus_one_wait: assert property (
    (accept && CLK_EN_IN) |=> !HREADYOUT_OUT
      ##1 (HREADYOUT_OUT || !$past(CLK_EN_IN))
  ) else $error("transfer accepted without wait state");

endmodule

// [testbench/x1_source_model.sv]
// Purpose: crystal or external clock seen at the x1 pin
// Assumes: 20 MHz, above the 10 MHz gain threshold
// Notes: a stopped crystal gives no edges, so the pin rests low
`timescale 1ns/1ns
module x1_source_model #(
  parameter int HALF_NS = 25,
  parameter int START_NS = 300
) (
  input wire logic run_in,
  input wire logic ext_in,
  output logic clk_out
);
  // one process drives the pin; it always rests low between bursts
  always begin
    clk_out = 1'b0;
    wait (run_in || ext_in);
    // a resonator needs time to build up, an applied clock does not
    if (!ext_in) #(START_NS);
    // an external clock runs whenever it is applied, before any start
    while (run_in || ext_in) begin
      #(HALF_NS) clk_out = 1'b1;
      #(HALF_NS) clk_out = 1'b0;
    end
  end
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the cpu clock source switcher
// Assumes: one wait state per transfer, registers in bits 7:0
// Notes: reads are checked by a bus watcher against a queue of notes
`timescale 1ns/1ns
module tb_top
  import clock_switch_pkg::*;
;
  logic clk, nrst, clk_en, hsel, hwrite, ext_apply;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, cpu_peripheral_clock;
  logic [2:0] hsize;
  logic hready, hresp, hi_run, mid_run, lo_run, x1_run, ext_md, gain, x1_clk;
  logic [7:0] pins;
  logic [31:0] exp_q[$], mask_q[$];
  logic [31:0] e, m, q;
  logic rd_busy;
  int n_fail, checks;

  assign pins = {hi_run, mid_run, lo_run, x1_run, ext_md, gain, cpu_peripheral_clock};

  cpu_clock_source_switcher uut (
    .CORE_CLK_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(clk_en),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .X1_CLK_IN(x1_clk), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .HIGH_OSC_RUN_OUT(hi_run), .MIDDLE_OSC_RUN_OUT(mid_run),
    .LOW_OSC_RUN_OUT(lo_run), .X1_OSC_RUN_OUT(x1_run),
    .X1_EXT_MODE_OUT(ext_md), .X1_GAIN_HIGH_OUT(gain),
    .CPU_PERIPHERAL_CLOCK_SRC_OUT(cpu_peripheral_clock)
  );

  x1_source_model xtal (
    .run_in(x1_run), .ext_in(ext_apply), .clk_out(x1_clk)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // watcher: a read result appears when its data phase ends
  always @(posedge clk) begin
    if (rd_busy && hready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("MISMATCH t=%0t read without a note", $time);
      end else begin
        e = exp_q.pop_front();
        m = mask_q.pop_front();
        checks++;
        if ((hrdata & m) !== (e & m) || hresp !== 1'b0) begin
          n_fail++;
          $display("MISMATCH t=%0t read %h exp %h", $time, hrdata, e);
        end
      end
    end
    if (hready === 1'b1) rd_busy = hsel & htrans[1] & ~hwrite;
  end

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("MISMATCH t=%0t bus hang", $time);
      give_verdict();
    end
  endtask

  // upper address and data bits are random: only bits 7:0 matter
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'($urandom), a};
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'($urandom), d};
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input logic [7:0] mk);
    exp_q.push_back({24'h0, x});
    mask_q.push_back({24'hFFFFFF, mk});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic poll(input logic [7:0] a, input logic [7:0] mk,
                      input logic [7:0] v);
    int n;
    n = 0;
    do begin
      rd(a, 8'h00, 8'h00);
      n++;
    end while ((q[7:0] & mk) !== v && n < 3000);
    check(q[7:0] & mk, v, "status poll");
    if ((q[7:0] & mk) !== v) give_verdict();
  endtask

  task automatic pins_are(input logic [7:0] x);
    @(negedge clk);
    check(pins, x, "oscillator pins");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  logic [7:0] ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [7:0] rst_v[7] = '{8'hC1, 8'hC0, 8'h01, 8'h00, 8'h07, 8'h00, 8'h00};

  initial begin
    n_fail = 0;
    checks = 0;
    rd_busy = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    ext_apply = 1'b0;
    void'($urandom(32'h2849));
    idle(10);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ofs[i], rst_v[i], 8'hFF);
    pins_are(8'h23);
    wr(OFS_STAB_STAT, 8'hFF);
    rd(OFS_STAB_STAT, 8'h00, 8'hFF);
    wr(8'h1C + 8'(4 * ($urandom % 57)), 8'hFF);
    rd(8'h1C + 8'(4 * ($urandom % 57)), 8'h00, 8'hFF);
    // low-speed to high-speed on-chip
    wr(OFS_OSC_RUN, 8'hC0);
    pins_are(8'hA3);
    idle(6500);
    wr(OFS_SYS_SEL, 8'h00);
    poll(OFS_SYS_SEL, 8'h80, 8'h00);
    rd(OFS_SYS_SEL, 8'h00, 8'hF3);
    pins_are(8'hA0);
    wr(OFS_SUB_SEL, 8'h00);
    pins_are(8'h80);
    wr(OFS_SUPPLY, 8'h01);
    pins_are(8'hA0);
    wr(OFS_SUB_SEL, 8'h01);
    wr(OFS_SUPPLY, 8'h00);
    pins_are(8'hA0);
    // middle-speed on-chip and back
    wr(OFS_OSC_RUN, 8'hC2);
    pins_are(8'hE0);
    idle(400);
    wr(OFS_SYS_SEL, 8'h01);
    poll(OFS_SYS_SEL, 8'h02, 8'h02);
    pins_are(8'hE1);
    wr(OFS_SYS_SEL, 8'h00);
    poll(OFS_SYS_SEL, 8'h02, 8'h00);
    wr(OFS_OSC_RUN, 8'hC0);
    pins_are(8'hA0);
    // x1 crystal at 20 MHz needs the high gain setting
    wr(OFS_MODE, 8'h41);
    pins_are(8'hA4);
    wr(OFS_STAB_SEL, 8'h02);
    rd(OFS_STAB_SEL, 8'h02, 8'h07);
    wr(OFS_OSC_RUN, 8'h40);
    pins_are(8'hB4);
    // enable low must freeze the counter while the crystal keeps running
    @(posedge clk) clk_en <= 1'b0;
    idle(3000);
    clk_en <= 1'b1;
    rd(OFS_STAB_STAT, 8'h00, 8'hFF);
    poll(OFS_STAB_STAT, 8'hFF, 8'hE0);
    idle(11000);
    rd(OFS_STAB_STAT, 8'hE0, 8'hFF);
    wr(OFS_SYS_SEL, 8'h10);
    poll(OFS_SYS_SEL, 8'h20, 8'h20);
    pins_are(8'hB6);
    wr(OFS_OSC_RUN, 8'h41);
    pins_are(8'h36);
    // back to the low-speed oscillator, then stop x1
    wr(OFS_SYS_SEL, 8'h50);
    poll(OFS_SYS_SEL, 8'h80, 8'h80);
    pins_are(8'h37);
    wr(OFS_OSC_RUN, 8'hC1);
    pins_are(8'h27);
    rd(OFS_STAB_STAT, 8'h00, 8'hFF);
    // external clock applied before the stop bit is cleared
    ext_apply <= 1'b1;
    wr(OFS_MODE, 8'hC1);
    pins_are(8'h2F);
    wr(OFS_OSC_RUN, 8'h41);
    pins_are(8'h3F);
    wr(OFS_SYS_SEL, 8'h10);
    poll(OFS_SYS_SEL, 8'h80, 8'h00);
    pins_are(8'h3E);
    idle(5);
    give_verdict();
  end
endmodule
